// file: src/pwd_cfg.svh
`ifndef PWD_CFG_SVH
`define PWD_CFG_SVH
`define PWD_WORD_W 21
`define PWD_IDX_MSB 20
`define PWD_IDX_LSB 17
`define PWD_N_MSB 16
`define PWD_N_LSB 10
`define PWD_R_MSB 9
`define PWD_R_LSB 7
`define PWD_M_MSB 6
`define PWD_M_LSB 0
`define PWD_N_OFFSET 8'h03
`define PWD_M_OFFSET 8'h02
`define PWD_IDX_VOFF 4'hE
`define PWD_IDX_VMUX 4'hF
`define PWD_CTL_MODE_BIT 21
`define PWD_CTL_NS2_BIT 15
`define PWD_CTL_NS1_BIT 14
`define PWD_CTL_NS0_BIT 13
`define PWD_CTL_RESET 22'h02_0000
`define PWD_DIVCODE_RESET 4'h8
`define PWD_DIV_MAX 6'h20
`endif

// file: src/pwd_pkg.sv
package pwd_pkg;
  typedef enum logic [1:0] {RUN, SLEEP1, SLEEP2} pwd_mode_t;
  typedef struct packed {
    logic [3:0] idx;
    logic [6:0] nField;
    logic [2:0] mux;
    logic [6:0] mField;
  } pwd_word_t;
endpackage

// file: src/pwd_ref_div.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwd_cfg.svh"
// Divides the clock by an even divisor; a zero divisor parks the output high.
module pwd_ref_div (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic run,
  input wire logic [5:0] divisor,
  output logic clkOut
);
  logic [5:0] cnt_q;
  logic out_q;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q <= 6'h00;
      out_q <= 1'b1;
    end
    else if (ce)
    begin
      if (!run || divisor == 6'h00)
      begin
        cnt_q <= 6'h00;
        out_q <= 1'b1;
      end
      else if (cnt_q >= divisor[5:1] - 6'h01)
      begin
        cnt_q <= 6'h00;
        out_q <= ~out_q;
      end
      else
      begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end
  assign clkOut = out_q;
endmodule // pwd_ref_div
`default_nettype wire

// file: src/pll_word_decode_powerdown.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwd_cfg.svh"
// Behaviour
// - Word is index(4), N(7), mux(3), M(7), index MSB first, M LSB last.
// - VCO divider is N field plus three, reference divider M field plus two.
// - Output divisor is two raised to the mux field, 1 up to 128.
// - Index is don't-care except 1110 and 1111; 1110 turns video clock off.
// - Index 1111 powers down video VCO and routes memory VCO to video channel.
// - Mode 1 stops VCOs, holds video clock high, memory clock is ref over divisor.
// - Divisor code 1 gives 32, minus two per step to 4 at F; reset 8.
// - Mode 2 needs mode bit set before pin low; all stops, registers kept.
// - Pin back high leaves either power-down mode and resumes normal output.
// - Control bit 21 selects mode 1 when zero, mode 2 when one.
// - Control bits 15, 14, 13 pick prescale 2 or 4 for registers 2, 1, 0.
module pll_word_decode_powerdown (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic sleep_request_n,
  input wire logic [21:0] control_word,
  input wire logic ctlWrite,
  input wire logic [20:0] memWord,
  input wire logic [20:0] vidWord,
  input wire logic [1:0] vidSel,
  input wire logic wordWrite,
  input wire logic [3:0] sleep_divisor_code,
  input wire logic divWrite,
  output logic [7:0] memNDiv,
  output logic [7:0] memMDiv,
  output logic [7:0] memOutDiv,
  output logic [2:0] memPrescale,
  output logic [7:0] vidNDiv,
  output logic [7:0] vidMDiv,
  output logic [7:0] vidOutDiv,
  output logic [2:0] vidPrescale,
  output logic memVcoOn,
  output logic vidVcoOn,
  output logic vidFromMem,
  output logic vidClockOff,
  output logic refOscOn,
  output logic memUseRefDiv,
  output logic memRefClk,
  output logic video_clock_out_force_high,
  output logic [5:0] sleepDivisor,
  output logic [1:0] sleepMode
);
  logic pinMeta_q;
  logic pinSync_q;
  logic [21:0] ctl_q;
  logic [3:0] divCode_q;
  logic [20:0] mem_q;
  logic [20:0] vid_q;
  logic [1:0] vidSel_q;
  pwd_pkg::pwd_mode_t mode_q;
  pwd_pkg::pwd_mode_t mode_d;
  pwd_pkg::pwd_word_t memW;
  pwd_pkg::pwd_word_t vidW;

  // Expands a 3-bit mux code into its power-of-two divisor.
  function automatic logic [7:0] outDiv(input logic [2:0] r);
    outDiv = 8'h01 << r;
  endfunction

  // Prescale of 2 or 4 from the control bit of the selected frequency register.
  function automatic logic [2:0] prescale(input logic [21:0] c, input logic [1:0] sel);
    logic b;
    b = 1'b0;
    case (sel)
      2'd0: b = c[`PWD_CTL_NS0_BIT];
      2'd1: b = c[`PWD_CTL_NS1_BIT];
      default: b = c[`PWD_CTL_NS2_BIT];
    endcase
    prescale = b ? 3'h4 : 3'h2;
  endfunction

  // Code 0 has no defined divisor, so it yields zero and the output parks.
  function automatic logic [5:0] codeToDiv(input logic [3:0] code);
    if (code == 4'h0)
    begin
      codeToDiv = 6'h00;
    end
    else
    begin
      codeToDiv = `PWD_DIV_MAX - {1'b0, code - 4'h1, 1'b0};
    end
  endfunction

  // The pin is asynchronous to clk, so it is synchronised before use.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pinMeta_q <= 1'b1;
      pinSync_q <= 1'b1;
    end
    else if (ce)
    begin
      pinMeta_q <= sleep_request_n;
      pinSync_q <= pinMeta_q;
    end
  end

  // Registers keep their contents across either power-down mode.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctl_q <= `PWD_CTL_RESET;
      divCode_q <= `PWD_DIVCODE_RESET;
      mem_q <= 21'h00_0000;
      vid_q <= 21'h00_0000;
      vidSel_q <= 2'h0;
    end
    else if (ce && mode_q == pwd_pkg::RUN)
    begin
      if (ctlWrite)
      begin
        ctl_q <= control_word;
      end
      if (divWrite)
      begin
        divCode_q <= sleep_divisor_code;
      end
      if (wordWrite)
      begin
        mem_q <= memWord;
        vid_q <= vidWord;
        vidSel_q <= vidSel;
      end
    end
  end

  // The mode bit is sampled when the synchronised pin first reads low in RUN, so it must be set by then.
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      pwd_pkg::RUN:
      begin
        if (!pinSync_q)
        begin
          mode_d = ctl_q[`PWD_CTL_MODE_BIT] ? pwd_pkg::SLEEP2 : pwd_pkg::SLEEP1;
        end
      end
      pwd_pkg::SLEEP1, pwd_pkg::SLEEP2:
      begin
        if (pinSync_q)
        begin
          mode_d = pwd_pkg::RUN;
        end
      end
      default: mode_d = pwd_pkg::RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_q <= pwd_pkg::RUN;
    end
    else if (ce)
    begin
      mode_q <= mode_d;
    end
  end

  assign memW = mem_q;
  assign vidW = vid_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      memNDiv <= 8'h03;
      memMDiv <= 8'h02;
      memOutDiv <= 8'h01;
      memPrescale <= 3'h2;
      vidNDiv <= 8'h03;
      vidMDiv <= 8'h02;
      vidOutDiv <= 8'h01;
      vidPrescale <= 3'h2;
      memVcoOn <= 1'b1;
      vidVcoOn <= 1'b1;
      vidFromMem <= 1'b0;
      vidClockOff <= 1'b0;
      refOscOn <= 1'b1;
      memUseRefDiv <= 1'b0;
      video_clock_out_force_high <= 1'b0;
      sleepDivisor <= 6'h12;
      sleepMode <= 2'h0;
    end
    else if (ce)
    begin
      memNDiv <= {1'b0, memW.nField} + `PWD_N_OFFSET;
      memMDiv <= {1'b0, memW.mField} + `PWD_M_OFFSET;
      memOutDiv <= outDiv(memW.mux);
      memPrescale <= 3'h2;
      vidNDiv <= {1'b0, vidW.nField} + `PWD_N_OFFSET;
      vidMDiv <= {1'b0, vidW.mField} + `PWD_M_OFFSET;
      vidOutDiv <= outDiv(vidW.mux);
      vidPrescale <= prescale(ctl_q, vidSel_q);
      sleepDivisor <= codeToDiv(divCode_q);
      sleepMode <= mode_q;
      memVcoOn <= mode_q == pwd_pkg::RUN;
      vidVcoOn <= mode_q == pwd_pkg::RUN && vidW.idx != `PWD_IDX_VMUX
                  && vidW.idx != `PWD_IDX_VOFF;
      vidFromMem <= mode_q == pwd_pkg::RUN && vidW.idx == `PWD_IDX_VMUX;
      vidClockOff <= mode_q == pwd_pkg::SLEEP2 || vidW.idx == `PWD_IDX_VOFF;
      video_clock_out_force_high <= mode_q == pwd_pkg::SLEEP1;
      memUseRefDiv <= mode_q == pwd_pkg::SLEEP1;
      refOscOn <= mode_q != pwd_pkg::SLEEP2;
    end
  end

  // Memory clock in mode 1 is the reference divided by the power-down divisor.
  pwd_ref_div uRefDiv (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .run(mode_q == pwd_pkg::SLEEP1),
    .divisor(codeToDiv(divCode_q)),
    .clkOut(memRefClk)
  );

  a_mode2_entry: assert property (@(posedge clk) disable iff (!rstn)
    ce && mode_q == pwd_pkg::RUN && !pinSync_q && ctl_q[21] |=> mode_q == pwd_pkg::SLEEP2)
    else $error("mode 2 not entered");
  a_mode1_entry: assert property (@(posedge clk) disable iff (!rstn)
    ce && mode_q == pwd_pkg::RUN && !pinSync_q && !ctl_q[21] |=> mode_q == pwd_pkg::SLEEP1)
    else $error("mode 1 not entered");
  a_wake_up: assert property (@(posedge clk) disable iff (!rstn)
    ce && mode_q != pwd_pkg::RUN && pinSync_q |=> mode_q == pwd_pkg::RUN)
    else $error("no wake on pin high");
  a_vid_high: assert property (@(posedge clk) disable iff (!rstn)
    ce && mode_q == pwd_pkg::SLEEP1 |=> video_clock_out_force_high && !memVcoOn && !vidVcoOn)
    else $error("mode 1 outputs wrong");
  a_osc_off: assert property (@(posedge clk) disable iff (!rstn)
    ce && mode_q == pwd_pkg::SLEEP2 |=> !refOscOn && vidClockOff)
    else $error("mode 2 outputs wrong");
  a_n_divider: assert property (@(posedge clk) disable iff (!rstn)
    ce |=> memNDiv == {1'b0, $past(mem_q[16:10])} + 8'h03)
    else $error("N divider wrong");
  a_m_divider: assert property (@(posedge clk) disable iff (!rstn)
    ce |=> vidMDiv == {1'b0, $past(vid_q[6:0])} + 8'h02)
    else $error("M divider wrong");
  a_out_div: assert property (@(posedge clk) disable iff (!rstn)
    ce |=> vidOutDiv == 8'h01 << $past(vid_q[9:7]))
    else $error("output divisor wrong");
  a_sleep_div: assert property (@(posedge clk) disable iff (!rstn)
    ce && divCode_q == 4'h8 |=> sleepDivisor == 6'h12)
    else $error("divisor code 8 not 18");
  a_vid_mux: assert property (@(posedge clk) disable iff (!rstn)
    ce && mode_q == pwd_pkg::RUN && vid_q[20:17] == 4'hF |=> vidFromMem && !vidVcoOn)
    else $error("video mux wrong");
  a_mem_vco_kept: assert property (@(posedge clk) disable iff (!rstn)
    ce && mode_q == pwd_pkg::RUN && vid_q[20:17] == 4'hE |=> memVcoOn && vidClockOff)
    else $error("index 1110 wrong");
  c_mode1: cover property (@(posedge clk) mode_q == pwd_pkg::SLEEP1 ##1 mode_q == pwd_pkg::RUN);
  c_mode2: cover property (@(posedge clk) mode_q == pwd_pkg::SLEEP2);
  c_vmux: cover property (@(posedge clk) vidFromMem);
  c_refclk: cover property (@(posedge clk) memUseRefDiv && $rose(memRefClk));
endmodule // pll_word_decode_powerdown
`default_nettype wire

// file: testbench/pwd_host.sv
`timescale 1ns/1ps
`default_nettype none
module pwd_host (
  input wire logic clk,
  output logic ctlWrite,
  output logic [21:0] control_word,
  output logic wordWrite,
  output logic [20:0] memWord,
  output logic [20:0] vidWord,
  output logic [1:0] vidSel,
  output logic divWrite,
  output logic [3:0] sleep_divisor_code,
  output logic sleep_request_n
);
  initial
  begin
    {ctlWrite, wordWrite, divWrite, memWord, vidWord, vidSel, sleep_divisor_code} = '0;
    control_word = 22'h02_0000;
    sleep_request_n = 1'b1;
  end
  // Data other than vidSel is inverted after each strobe so a late sample shows up as a wrong value.
  task automatic putWord(input logic [20:0] m, input logic [20:0] v, input logic [1:0] s);
    @(negedge clk);
    memWord = m;
    vidWord = v;
    vidSel = s;
    wordWrite = 1'b1;
    @(negedge clk);
    wordWrite = 1'b0;
    memWord = ~m;
    vidWord = ~v;
  endtask
  task automatic putCtl(input logic [21:0] c);
    @(negedge clk);
    control_word = c;
    ctlWrite = 1'b1;
    @(negedge clk);
    ctlWrite = 1'b0;
    control_word = ~c;
  endtask
  task automatic putDiv(input logic [3:0] d);
    @(negedge clk);
    sleep_divisor_code = d;
    divWrite = 1'b1;
    @(negedge clk);
    divWrite = 1'b0;
    sleep_divisor_code = ~d;
  endtask
  // The mode bit is always written before the pin is pulled low.
  task automatic setPin(input logic b);
    @(negedge clk);
    sleep_request_n = b;
  endtask
endmodule // pwd_host
`default_nettype wire

// file: testbench/pll_word_decode_powerdown_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pll_word_decode_powerdown_bench;
  logic clk, rstn, ce, ctlWrite, wordWrite, divWrite, sleep_request_n;
  logic [21:0] control_word, cw;
  logic [20:0] memWord, vidWord;
  logic [1:0] vidSel, sel, sleepMode;
  logic [3:0] sleep_divisor_code;
  logic [7:0] memNDiv, memMDiv, memOutDiv, vidNDiv, vidMDiv, vidOutDiv;
  logic [2:0] memPrescale, vidPrescale;
  logic memVcoOn, vidVcoOn, vidFromMem, vidClockOff, refOscOn, memUseRefDiv, memRefClk, fh;
  logic prevClk;
  logic [5:0] sleepDivisor;
  logic [31:0] seed;
  pwd_pkg::pwd_word_t w, v;
  int n_mismatch, checked, tog;
  pll_word_decode_powerdown dut_u (.clk(clk), .rstn(rstn), .ce(ce),
    .sleep_request_n(sleep_request_n), .control_word(control_word), .ctlWrite(ctlWrite),
    .memWord(memWord), .vidWord(vidWord), .vidSel(vidSel), .wordWrite(wordWrite),
    .sleep_divisor_code(sleep_divisor_code), .divWrite(divWrite), .memNDiv(memNDiv),
    .memMDiv(memMDiv), .memOutDiv(memOutDiv), .memPrescale(memPrescale), .vidNDiv(vidNDiv),
    .vidMDiv(vidMDiv), .vidOutDiv(vidOutDiv), .vidPrescale(vidPrescale), .memVcoOn(memVcoOn),
    .vidVcoOn(vidVcoOn), .vidFromMem(vidFromMem), .vidClockOff(vidClockOff),
    .refOscOn(refOscOn), .memUseRefDiv(memUseRefDiv), .memRefClk(memRefClk),
    .video_clock_out_force_high(fh), .sleepDivisor(sleepDivisor), .sleepMode(sleepMode));
  pwd_host host_u (.clk(clk), .ctlWrite(ctlWrite), .control_word(control_word),
    .wordWrite(wordWrite), .memWord(memWord), .vidWord(vidWord), .vidSel(vidSel),
    .divWrite(divWrite), .sleep_divisor_code(sleep_divisor_code),
    .sleep_request_n(sleep_request_n));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // A legal word keeps the VCO in band for either prescale with a 40 MHz reference.
  // N near eleven sixteenths of M leaves half a step of margin at both band edges.
  function automatic pwd_pkg::pwd_word_t legal(input logic [31:0] r);
    pwd_pkg::pwd_word_t x;
    int m;
    x = r[20:0];
    m = 9 + int'(r[31:25]) % 121;
    x.mField = 7'(m - 2);
    x.nField = 7'((11 * m + 8) / 16 - 3);
    return x;
  endfunction
  // Each code step above one takes two off the largest divisor.
  function automatic logic [7:0] expSleepDiv(input int c);
    return (c == 0) ? 8'h00 : 8'(34 - 2 * c);
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  initial
  begin
    ce = 1'b1;
    rstn = 1'b0;
    seed = 32'hd7aa_6a2e;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    chk(memNDiv, 8'h03);
    chk(sleepDivisor, 8'h12);
    for (int i = 0; i < 24; i++)
    begin
      seed = xs(seed);
      w = legal(seed);
      cw = 22'h02_0000 | {seed[23:21], 13'h0000};
      seed = xs(seed);
      v = legal(seed);
      sel = seed[22:21] % 2'h3;
      if (i % 4 > 1) v.idx = 4'hC + 4'(i % 4); // Forces both special index codes.
      if (i == 0) w = '1;
      host_u.putCtl(cw);
      host_u.putWord(w, v, sel);
      repeat (2) @(negedge clk);
      chk(memNDiv, w.nField + 8'h03);
      chk(memMDiv, w.mField + 8'h02);
      chk(vidNDiv, v.nField + 8'h03);
      chk(vidMDiv, v.mField + 8'h02);
      chk(memOutDiv, 8'h01 << w.mux);
      chk(vidOutDiv, 8'h01 << v.mux);
      chk(vidPrescale, cw[13 + sel] ? 8'h04 : 8'h02);
      chk(memPrescale, 8'h02);
      chk(vidClockOff, v.idx == 4'hE);
      chk(memVcoOn, 8'h01);
      chk(vidFromMem, v.idx == 4'hF);
      chk(vidVcoOn, v.idx != 4'hF && v.idx != 4'hE);
    end
    // With the enable low a strobed write must be lost and the memory N and video M outputs must hold.
    ce = 1'b0;
    host_u.putWord(~w, ~v, sel);
    ce = 1'b1;
    repeat (2) @(negedge clk);
    chk(memNDiv, w.nField + 8'h03);
    chk(vidMDiv, v.mField + 8'h02);
    for (int c = 0; c < 16; c++)
    begin
      host_u.putDiv(4'(c));
      repeat (2) @(negedge clk);
      chk(sleepDivisor, expSleepDiv(c));
    end
    host_u.setPin(1'b0);
    repeat (6) @(negedge clk);
    chk(sleepMode, 8'h01);
    chk(fh, 8'h01);
    chk(memUseRefDiv, 8'h01);
    chk(memVcoOn | vidVcoOn, 8'h00);
    tog = 0;
    prevClk = memRefClk;
    repeat (16)
    begin
      @(negedge clk);
      tog += int'(memRefClk !== prevClk);
      prevClk = memRefClk;
    end
    chk(8'(tog), 8'h08);
    // A write while asleep must leave the divisor alone.
    host_u.putDiv(4'h1);
    repeat (2) @(negedge clk);
    chk(sleepDivisor, 8'h04);
    host_u.setPin(1'b1);
    repeat (6) @(negedge clk);
    chk(sleepMode, 8'h00);
    chk(fh, 8'h00);
    host_u.putCtl(22'h22_0000);
    host_u.setPin(1'b0);
    repeat (6) @(negedge clk);
    chk(sleepMode, 8'h02);
    chk(refOscOn, 8'h00);
    host_u.setPin(1'b1);
    repeat (6) @(negedge clk);
    chk(refOscOn, 8'h01);
    chk(memNDiv, w.nField + 8'h03);
    summarize();
  end
endmodule // pll_word_decode_powerdown_bench
`default_nettype wire
